// ---- core/adcfmt_ctrl.sv ----
// Converter control, result formatting and reference select logic
`timescale 1ns/1ns
`default_nettype none
`include "adcfmt_params.svh"

// Operation
// (R1) Bit 7 selects right or left justification
// (R2) Bit 5 picks low-reference pin or ground
// (R3) Bit 4 picks high-reference pin or supply
// (R4) Left format: 9..2 upper, 1..0 lower top
// (R5) Right format: 9..8 upper bottom, 7..0 lower
// (R6) Bits 6 and 3..0 read zero, ignore writes
// (R7) Software acquires input before starting conversion
// (R8) Software waits after channel change, impedance sized
// (R9) Result bytes undefined at power-on, else kept
// (R10) Conversion resolves 1024 codes, half-step accuracy
// (R11) Completion clears go, sets flag, loads result
// (R12) Abort keeps previous result, no partial write
// (R13) Clock select: divide 2, 8, 32, RC
// (R14) Channel select: inputs 0-13, comparator, fixed
// (R15) Both result bytes update in one cycle
module adcfmt_ctrl
    import adcfmt_pkg::*;
(
    input wire logic MCLK, // System clock, 250 MHz
    input wire logic RST, // Asynchronous reset, active high
    input wire logic PWR_RST, // Power-on or brown-out reset cause
    input wire logic [2:0] ADDR, // Register address
    input wire logic [7:0] WDATA, // Write data
    input wire logic WR_EN, // Write strobe
    input wire logic RD_EN, // Read strobe
    output logic [7:0] RDATA, // Read data, cycle after strobe
    input wire logic [9:0] SAR_CODE, // Comparator result from analog SAR
    input wire logic TRIGGER, // Hardware start request, same domain
    output logic [3:0] CHANNEL_SEL, // Analog mux select
    output logic NEG_REF_SEL, // 1 = low-reference pin, 0 = ground
    output logic POS_REF_SEL, // 1 = high-reference pin, 0 = supply
    output logic ANALOG_EN, // Analog front end powered
    output logic SAMPLE_HOLD, // Hold capacitor disconnected, converting
    output logic BIT_STROBE, // One pulse per conversion bit period
    output logic IRQ // Level interrupt
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // Place a 10-bit code into the byte pair per justification
    function automatic adcfmt_res_t place_result(input logic [9:0] code,
                                                 input logic right);
        adcfmt_res_t r;
        r = '0;
        if (right)
        begin
            r.upper = {6'h00, code[9:8]}; // R5
            r.lower = code[7:0]; // R5
        end
        else
        begin
            r.upper = code[9:2]; // R4
            r.lower = {code[1:0], 6'h00}; // R4
        end
        return r;
    endfunction

    // Divider ratio for the bit period clock
    function automatic logic [7:0] div_ratio(input logic [1:0] sel);
        logic [7:0] d;
        d = `ADCFMT_DIV_2;
        case (sel)
            2'h0: d = `ADCFMT_DIV_2; // R13
            2'h1: d = `ADCFMT_DIV_8; // R13
            2'h2: d = `ADCFMT_DIV_32; // R13
            default: d = `ADCFMT_DIV_RC; // R13
        endcase
        return d;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************

    adcfmt_ctrl_t ctrl_q, ctrl_d; // Main control register
    logic [7:0] fmt_q, fmt_d; // Format and reference register
    adcfmt_res_t res_q, res_d; // Result byte pair
    logic res_valid_q, res_valid_d; // Result written since power-on
    logic [7:0] stat_q, stat_d; // Sticky interrupt status
    logic [7:0] mask_q, mask_d; // Interrupt mask
    adcfmt_state_t state_q, state_d; // Sequencer state
    logic [7:0] div_q, div_d; // Bit period divider
    logic [4:0] bits_q, bits_d; // Bit periods remaining
    logic [7:0] rdata_q, rdata_d; // Registered read data
    logic bit_tick; // End of a bit period
    logic done_evt; // Conversion completes this cycle

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Bit period tick: divider wraps at the selected ratio
    assign bit_tick = (state_q != ADCFMT_IDLE) &&
        (div_q == div_ratio(ctrl_q.conv_clock_sel) - 8'd1);

    // Next state of sequencer and divider
    always_comb
    begin
        state_d = state_q;
        div_d = div_q;
        bits_d = bits_q;
        done_evt = 1'b0;
        case (state_q)
            ADCFMT_IDLE:
            begin
                div_d = 8'h00;
                // Start on go, only while powered
                if (ctrl_q.go && ctrl_q.converter_power_on)
                begin
                    state_d = ADCFMT_CONV;
                    bits_d = `ADCFMT_BITS_PER_CONV;
                end
            end
            ADCFMT_CONV:
            begin
                div_d = bit_tick ? 8'h00 : div_q + 8'd1;
                if (!ctrl_q.go || !ctrl_q.converter_power_on)
                begin
                    // Aborted: enforce a quiet gap before next start
                    state_d = ADCFMT_HOLDOFF; // R12
                    div_d = 8'h00;
                    bits_d = `ADCFMT_ABORT_PERIODS;
                end
                else if (bit_tick)
                begin
                    bits_d = bits_q - 5'd1;
                    if (bits_q == 5'd1)
                    begin
                        done_evt = 1'b1; // R11
                        state_d = ADCFMT_IDLE;
                    end
                end
            end
            ADCFMT_HOLDOFF:
            begin
                div_d = bit_tick ? 8'h00 : div_q + 8'd1;
                if (bit_tick)
                begin
                    bits_d = bits_q - 5'd1;
                    if (bits_q == 5'd1)
                    begin
                        state_d = ADCFMT_IDLE;
                    end
                end
            end
            default:
            begin
                state_d = ADCFMT_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            state_q <= ADCFMT_IDLE;
            div_q <= 8'h00;
            bits_q <= 5'h00;
        end
        else
        begin
            state_q <= state_d;
            div_q <= div_d;
            bits_q <= bits_d;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************

    // Software writes, hardware updates; hardware set wins over clear
    always_comb
    begin
        ctrl_d = ctrl_q;
        fmt_d = fmt_q;
        res_d = res_q;
        res_valid_d = res_valid_q;
        stat_d = stat_q;
        mask_d = mask_q;
        if (WR_EN)
        begin
            case (ADDR)
                `ADCFMT_OFS_CTRL_MAIN: ctrl_d = adcfmt_ctrl_t'(WDATA);
                // Unimplemented bits are dropped on write
                `ADCFMT_OFS_FMT_REF:
                    fmt_d = WDATA & `ADCFMT_FMT_REF_MASK; // R6
                // A software write counts as a defined result
                `ADCFMT_OFS_RES_UPPER:
                begin
                    res_d.upper = WDATA;
                    res_valid_d = 1'b1;
                end
                `ADCFMT_OFS_RES_LOWER:
                begin
                    res_d.lower = WDATA;
                    res_valid_d = 1'b1;
                end
                `ADCFMT_OFS_IRQ_STAT: stat_d = stat_q & ~WDATA;
                `ADCFMT_OFS_IRQ_MASK: mask_d = WDATA & `ADCFMT_IRQ_MASK;
                default: ;
            endcase
        end
        // Hardware trigger sets go, only while the converter is powered
        if (TRIGGER && ctrl_q.converter_power_on)
        begin
            ctrl_d.go = 1'b1;
        end
        if (done_evt)
        begin
            ctrl_d.go = 1'b0; // R11
            stat_d[`ADCFMT_IRQ_DONE_BIT] = 1'b1; // R11
            // Whole pair in one edge, no torn read possible
            res_d = place_result(SAR_CODE,
                fmt_q[`ADCFMT_JUSTIFY_BIT]); // R1 R10 R15 R11
            res_valid_d = 1'b1;
        end
    end

    // Control registers: cleared by every reset
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_q <= adcfmt_ctrl_t'(`ADCFMT_CTRL_MAIN_RST);
            fmt_q <= `ADCFMT_FMT_REF_RST;
            stat_q <= 8'h00;
            mask_q <= 8'h00;
            rdata_q <= 8'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            fmt_q <= fmt_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    // Result pair has no async reset so it survives warm resets;
    // power-on causes mark it undefined instead
    always_ff @(posedge MCLK)
    begin
        if (RST && PWR_RST)
        begin
            res_valid_q <= 1'b0; // R9
        end
        else if (!RST)
        begin
            res_valid_q <= res_valid_d;
            res_q <= res_d; // R9
        end
    end

    // ****************************************************************
    // Read port
    // ****************************************************************

    // Read data mux, registered for the cycle after the strobe
    always_comb
    begin
        rdata_d = 8'h00;
        if (RD_EN)
        begin
            case (ADDR)
                `ADCFMT_OFS_CTRL_MAIN: rdata_d = 8'(ctrl_q);
                `ADCFMT_OFS_FMT_REF:
                    rdata_d = fmt_q & `ADCFMT_FMT_REF_MASK; // R6
                // Undefined pair reads as zero, keeps unknowns off the bus
                `ADCFMT_OFS_RES_UPPER:
                    rdata_d = res_valid_q ? res_q.upper : 8'h00; // R9
                `ADCFMT_OFS_RES_LOWER:
                    rdata_d = res_valid_q ? res_q.lower : 8'h00; // R9
                `ADCFMT_OFS_IRQ_STAT: rdata_d = stat_q;
                `ADCFMT_OFS_IRQ_MASK: rdata_d = mask_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign RDATA = rdata_q;
    assign CHANNEL_SEL = ctrl_q.input_channel_sel; // R14
    assign NEG_REF_SEL = fmt_q[`ADCFMT_NEGREF_BIT]; // R2
    assign POS_REF_SEL = fmt_q[`ADCFMT_POSREF_BIT]; // R3
    assign ANALOG_EN = ctrl_q.converter_power_on;
    assign SAMPLE_HOLD = (state_q == ADCFMT_CONV);
    assign BIT_STROBE = bit_tick && (state_q == ADCFMT_CONV);
    assign IRQ = |(stat_q & mask_q);

endmodule
`default_nettype wire

// ---- core/adcfmt_params.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef ADCFMT_PARAMS_SVH
`define ADCFMT_PARAMS_SVH

// Register offsets (byte-wide registers on the plain port)
`define ADCFMT_OFS_CTRL_MAIN 3'h0
`define ADCFMT_OFS_FMT_REF 3'h1
`define ADCFMT_OFS_RES_UPPER 3'h2
`define ADCFMT_OFS_RES_LOWER 3'h3
`define ADCFMT_OFS_IRQ_STAT 3'h4
`define ADCFMT_OFS_IRQ_MASK 3'h5

// Field positions in the main control register
`define ADCFMT_POWER_BIT 0
`define ADCFMT_GO_BIT 1
`define ADCFMT_CHAN_LSB 2
`define ADCFMT_CLKSEL_LSB 6

// Field positions in the format and reference register
`define ADCFMT_JUSTIFY_BIT 7
`define ADCFMT_NEGREF_BIT 5
`define ADCFMT_POSREF_BIT 4
`define ADCFMT_FMT_REF_MASK 8'hb0

// Interrupt status bit positions
`define ADCFMT_IRQ_DONE_BIT 0
`define ADCFMT_IRQ_MASK 8'h01

// Reset values
`define ADCFMT_CTRL_MAIN_RST 8'h00
`define ADCFMT_FMT_REF_RST 8'h00

// Conversion bit periods per conversion and after abort
`define ADCFMT_BITS_PER_CONV 5'd11
`define ADCFMT_ABORT_PERIODS 5'd2

// Clock division ratios; RC option modelled by a slow divider
`define ADCFMT_DIV_2 8'd2
`define ADCFMT_DIV_8 8'd8
`define ADCFMT_DIV_32 8'd32
`define ADCFMT_DIV_RC 8'd250

`endif

// ---- core/adcfmt_pkg.sv ----
// Types shared by the converter control block
package adcfmt_pkg;

    // Main control register layout
    typedef struct packed {
        logic [1:0] conv_clock_sel;
        logic [3:0] input_channel_sel;
        logic go;
        logic converter_power_on;
    } adcfmt_ctrl_t;

    // Reference and format selects as they leave the block
    typedef struct packed {
        logic result_justify_sel;
        logic neg_ref_sel;
        logic pos_ref_sel;
    } adcfmt_fmt_t;

    // Result byte pair
    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] lower;
    } adcfmt_res_t;

    // Converter sequencing states
    typedef enum logic [1:0] {
        ADCFMT_IDLE,
        ADCFMT_CONV,
        ADCFMT_HOLDOFF
    } adcfmt_state_t;

endpackage

// ---- dv/adcfmt_ctrl_asserts.sv ----
// Port checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module adcfmt_ctrl_asserts (
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [2:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [7:0] RDATA,
    input wire logic [3:0] CHANNEL_SEL,
    input wire logic NEG_REF_SEL,
    input wire logic POS_REF_SEL,
    input wire logic SAMPLE_HOLD,
    input wire logic BIT_STROBE,
    input wire logic IRQ
);
    // ****************
    // Assertions
    // ****************
    // One clock domain, so clock and reset are given once
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    neg_ref_wr_a:
        assert property (WR_EN && ADDR == 3'h1 |=> NEG_REF_SEL ==
            $past(WDATA[5])) else $error("neg ref select wrong");
    pos_ref_wr_a:
        assert property (WR_EN && ADDR == 3'h1 |=> POS_REF_SEL ==
            $past(WDATA[4])) else $error("pos ref select wrong");
    fmt_unimpl_a:
        assert property (RD_EN && ADDR == 3'h1 |=> !RDATA[6] &&
            RDATA[3:0] == 4'h0) else $error("unused bits not zero");
    chan_wr_a:
        assert property (WR_EN && ADDR == 3'h0 |=> CHANNEL_SEL ==
            $past(WDATA[5:2])) else $error("channel select wrong");
    strobe_conv_a:
        assert property (BIT_STROBE |-> SAMPLE_HOLD)
        else $error("strobe outside conversion");
    strobe_gap_a:
        assert property (BIT_STROBE |=> !BIT_STROBE)
        else $error("strobes too close");
    conv_hold_a:
        assert property ($rose(SAMPLE_HOLD) |-> SAMPLE_HOLD[*8])
        else $error("conversion too short");
    // Read data stands one cycle only
    rdata_idle_a:
        assert property (!RD_EN |=> RDATA == 8'h00)
        else $error("read data not idle");
    unmapped_rd_a:
        assert property (RD_EN && ADDR[2:1] == 2'b11 |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    mask_off_a:
        assert property (WR_EN && ADDR == 3'h5 && !WDATA[0] |=> !IRQ)
        else $error("masked interrupt seen");
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic MCLK, RST, PWR_RST, WR_EN, RD_EN;
    logic [2:0] ADDR;
    logic [7:0] WDATA, RDATA, v;
    logic [9:0] SAR_CODE, c;
    logic [3:0] CHANNEL_SEL;
    logic NEG_REF_SEL, POS_REF_SEL, ANALOG_EN, SAMPLE_HOLD, BIT_STROBE, IRQ;
    logic TRIGGER;
    // Acquisition wait after a channel change, about 4.8 us at 4 ns
    localparam int ACQ_CYC = 1200;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int n;
    // Rows: format write value, then expected readback
    logic [15:0] rows [4] = '{16'hffb0, 16'h4f00, 16'h2020, 16'h1010};
    logic [7:0] divs [4] = '{8'd2, 8'd8, 8'd32, 8'd250};
    adcfmt_ctrl adcfmt_ctrl_i (.MCLK(MCLK), .RST(RST), .PWR_RST(PWR_RST),
        .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .RDATA(RDATA), .SAR_CODE(SAR_CODE), .TRIGGER(TRIGGER),
        .CHANNEL_SEL(CHANNEL_SEL), .NEG_REF_SEL(NEG_REF_SEL),
        .POS_REF_SEL(POS_REF_SEL), .ANALOG_EN(ANALOG_EN),
        .SAMPLE_HOLD(SAMPLE_HOLD), .BIT_STROBE(BIT_STROBE), .IRQ(IRQ));
    // ****************
    // Clock and hang guard
    // ****************
    initial
    begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    // Ceiling well above the slow divider's conversion
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_count++;
            finish_test();
        end
    end
    // ****************
    // Tasks
    // ****************
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        compares++;
        if (s !== e)
        begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR_EN <= 1'b1;
        @(posedge MCLK);
        WR_EN <= 1'b0;
        // Let the write settle before outputs are looked at
        #1;
    endtask
    // Data is looked at in the one cycle it stands
    task rd(input logic [2:0] a, input logic [7:0] e, input string nm);
        @(posedge MCLK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge MCLK);
        RD_EN <= 1'b0;
        #1 chk(nm, RDATA, e);
    endtask
    task finish_test();
        $display("checks %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****************
    // Main sequence
    // ****************
    initial
    begin
        RST = 1'b1;
        PWR_RST = 1'b1;
        {WR_EN, RD_EN, ADDR, WDATA} = '0;
        SAR_CODE = 10'h000;
        TRIGGER = 1'b0;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        PWR_RST <= 1'b0;
        rd(3'h1, 8'h00, "fmt reset");
        rd(3'h0, 8'h00, "ctrl reset");
        rd(3'h7, 8'h00, "unmapped");
        for (int i = 0; i < 4; i++)
        begin
            wr(3'h1, rows[i][15:8]);
            rd(3'h1, rows[i][7:0], "fmt");
            chk("negref", {7'h0, NEG_REF_SEL}, {7'h0, rows[i][13]});
            chk("posref", {7'h0, POS_REF_SEL}, {7'h0, rows[i][12]});
        end
        wr(3'h5, 8'h01);
        // Every clock code, justification alternating
        for (int i = 0; i < 4; i++)
        begin
            c = 10'(10'h2d6 + 10'h111 * i);
            SAR_CODE <= c;
            wr(3'h1, {i[0], 7'h0});
            wr(3'h0, {i[1:0], 4'hd - i[3:0], 2'b01});
            repeat (ACQ_CYC) @(posedge MCLK);
            wr(3'h0, {i[1:0], 4'hd - i[3:0], 2'b11});
            n = 0;
            while (IRQ !== 1'b1 && n < 4000)
            begin
                @(posedge MCLK);
                #1;
                n++;
            end
            chk("late", {7'h0, n > 11 * divs[i] + 4}, 8'h00);
            chk("early", {7'h0, n < 11 * divs[i] - 2}, 8'h00);
            chk("chan", {4'h0, CHANNEL_SEL}, 8'hd - i);
            chk("power", {7'h0, ANALOG_EN}, 8'h01);
            rd(3'h0, {i[1:0], 4'hd - i[3:0], 2'b01}, "go clear");
            if (i[0])
            begin
                rd(3'h2, {6'h0, c[9:8]}, "right up");
                rd(3'h3, c[7:0], "right low");
            end
            else
            begin
                rd(3'h2, c[9:2], "left up");
                rd(3'h3, {c[1:0], 6'h0}, "left low");
            end
            wr(3'h5, 8'h00);
            chk("masked", {7'h0, IRQ}, 8'h00);
            wr(3'h5, 8'h01);
            chk("unmasked", {7'h0, IRQ}, 8'h01);
            wr(3'h4, 8'h01);
            chk("cleared", {7'h0, IRQ}, 8'h00);
        end
        // Abort mid-conversion: old result kept, no flag
        SAR_CODE <= 10'h0f0;
        wr(3'h0, 8'h01);
        repeat (ACQ_CYC) @(posedge MCLK);
        wr(3'h0, 8'h03);
        repeat (12) @(posedge MCLK);
        wr(3'h0, 8'h01);
        repeat (60) @(posedge MCLK);
        #1 chk("abort irq", {7'h0, IRQ}, 8'h00);
        rd(3'h3, c[7:0], "abort low");
        rd(3'h2, {6'h0, c[9:8]}, "abort up");
        // Warm reset keeps the result pair
        @(posedge MCLK);
        RST <= 1'b1;
        repeat (3) @(posedge MCLK);
        RST <= 1'b0;
        rd(3'h2, {6'h0, c[9:8]}, "kept up");
        rd(3'h3, c[7:0], "kept low");
        rd(3'h1, 8'h00, "fmt rst");
        // Hardware start ignored while the converter is off
        @(posedge MCLK);
        TRIGGER <= 1'b1;
        @(posedge MCLK);
        TRIGGER <= 1'b0;
        rd(3'h0, 8'h00, "trig unpowered");
        wr(3'h0, 8'h01);
        repeat (ACQ_CYC) @(posedge MCLK);
        TRIGGER <= 1'b1;
        @(posedge MCLK);
        TRIGGER <= 1'b0;
        rd(3'h0, 8'h03, "trig go");
        finish_test();
    end
endmodule
bind adcfmt_ctrl adcfmt_ctrl_asserts adcfmt_ctrl_asserts_i (.MCLK(MCLK),
    .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
    .RDATA(RDATA), .CHANNEL_SEL(CHANNEL_SEL), .NEG_REF_SEL(NEG_REF_SEL),
    .POS_REF_SEL(POS_REF_SEL), .SAMPLE_HOLD(SAMPLE_HOLD),
    .BIT_STROBE(BIT_STROBE), .IRQ(IRQ));
`default_nettype wire
